// ### src/rcm_map.svh
`ifndef RCM_MAP_SVH
`define RCM_MAP_SVH

// checker count and widths
`define RCM_NCHK           5
`define RCM_NLOS           3
`define RCM_CNT_W          24
`define RCM_WIN_W          16
`define RCM_LIM_W          8
`define RCM_ADDR_W         8

// per-checker register block: checker k sits at k * stride
`define RCM_OFS_CHK_STRIDE 8'h10
`define RCM_OFS_NOM        8'h00
`define RCM_OFS_ACC        8'h04
`define RCM_OFS_REJ        8'h08
`define RCM_OFS_WIN        8'h0C

// shared registers
`define RCM_OFS_LIMITS     8'h60
`define RCM_OFS_MASK       8'h64
`define RCM_OFS_STATUS     8'h68
`define RCM_OFS_EVENT      8'h6C

// field positions
`define RCM_LIM_GOOD_LSB   0
`define RCM_LIM_FAIL_LSB   8
`define RCM_STS_DISQ_LSB   8

// reset values
`define RCM_RST_NOM        24'h000010
`define RCM_RST_ACC        24'h000001
`define RCM_RST_REJ        24'h000002
`define RCM_RST_WIN        16'h0001
`define RCM_RST_GOOD       8'h02
`define RCM_RST_FAIL       8'h02
`define RCM_RST_MASK       5'h00

// measuring-clock step: loss-of-signal counts in doubled-clock units
`define RCM_LOS_INC        2'h2
`define RCM_ACT_INC        2'h1

`endif

// ### src/rcm_pkg.sv
`include "rcm_map.svh"

package rcm_pkg;
   typedef enum logic {
      RCM_ST_ARM,
      RCM_ST_MEAS
   } rcm_state_t;

   typedef logic [`RCM_CNT_W-1:0] rcm_cnt_t;
   typedef logic [`RCM_WIN_W-1:0] rcm_win_t;
   typedef logic [`RCM_LIM_W-1:0] rcm_lim_t;
endpackage

// ### src/rcm_chk_if.sv
`timescale 1ns/10ps

interface rcm_chk_if import rcm_pkg::*; ();
   rcm_cnt_t nom;
   rcm_cnt_t acc;
   rcm_cnt_t rej;
   rcm_win_t win;
   rcm_lim_t good_lim;
   rcm_lim_t fail_lim;
   logic     ref_edge;
   logic     sts;

   modport ctl (output nom, acc, rej, win, good_lim, fail_lim, ref_edge, input sts);
   modport mon (input nom, acc, rej, win, good_lim, fail_lim, ref_edge, output sts);
endinterface

// ### src/rcm_edge_det.sv
`timescale 1ns/10ps

module rcm_edge_det (
   // clock and reset
   input  wire logic i_core_clk,
   input  wire logic i_nrst,
   // reference level and its rising edge
   input  wire logic i_ref,
   output logic      o_rise
);
   logic prev_r;
   logic prev_nxt;

   always_comb begin
      prev_nxt = i_ref;
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         prev_r <= 1'b0;
      end else begin
         prev_r <= prev_nxt;
      end
   end

   assign o_rise = i_ref & ~prev_r;
endmodule

// ### src/rcm_checker.sv
`timescale 1ns/10ps
`include "rcm_map.svh"

module rcm_checker import rcm_pkg::*; #(
   parameter logic [1:0] INC       = `RCM_LOS_INC,
   parameter bit         FIXED_LIM = 1'b0
) (
   // clock and reset
   input  wire logic i_core_clk,
   input  wire logic i_nrst,
   // configuration in, status out
   rcm_chk_if.mon    mon
);
   rcm_state_t st_r, st_nxt;
   rcm_cnt_t   cnt_r, cnt_nxt;
   rcm_win_t   edg_r, edg_nxt;
   rcm_lim_t   good_r, good_nxt;
   rcm_lim_t   fail_r, fail_nxt;
   logic       sts_r, sts_nxt;

   logic [`RCM_CNT_W:0] hi_rej;
   logic [`RCM_CNT_W:0] hi_acc;
   rcm_cnt_t            lo_rej;
   rcm_cnt_t            lo_acc;
   rcm_cnt_t            meas;
   rcm_lim_t            glim;
   rcm_lim_t            flim;
   logic                judge;
   logic                tmo;
   logic                rej_hit;
   logic                acc_hit;

   always_comb begin
      hi_rej  = {1'b0, mon.nom} + {1'b0, mon.rej};
      hi_acc  = {1'b0, mon.nom} + {1'b0, mon.acc};
      lo_rej  = (mon.rej > mon.nom) ? '0 : mon.nom - mon.rej;
      lo_acc  = (mon.acc > mon.nom) ? '0 : mon.nom - mon.acc;
      glim    = FIXED_LIM ? `RCM_LIM_W'(1) : mon.good_lim;
      flim    = FIXED_LIM ? `RCM_LIM_W'(1) : mon.fail_lim;
      meas    = (cnt_r > ~`RCM_CNT_W'(INC)) ? '1 : cnt_r + `RCM_CNT_W'(INC);
      st_nxt  = st_r;
      cnt_nxt = cnt_r;
      edg_nxt = edg_r;
      judge   = 1'b0;
      tmo     = 1'b0;
      case (st_r)
         RCM_ST_ARM: begin
            if (mon.ref_edge) begin
               st_nxt  = RCM_ST_MEAS;
               cnt_nxt = '0;
               edg_nxt = '0;
            end
         end
         RCM_ST_MEAS: begin
            // window measured in measuring-clock cycles across win reference edges
            cnt_nxt = meas;
            if (mon.ref_edge) begin
               edg_nxt = edg_r + `RCM_WIN_W'(1);
               if (edg_nxt >= mon.win) begin
                  judge   = 1'b1;
                  cnt_nxt = '0;
                  edg_nxt = '0;
               end
            end else if ({1'b0, meas} > hi_rej) begin
               // missing edges: judge now and restart, so a stopped reference keeps failing
               judge   = 1'b1;
               tmo     = 1'b1;
               cnt_nxt = '0;
               edg_nxt = '0;
            end
         end
         default: st_nxt = RCM_ST_ARM;
      endcase

      rej_hit  = tmo | ({1'b0, meas} > hi_rej) | (meas < lo_rej);
      acc_hit  = !tmo && ({1'b0, meas} <= hi_acc) && (meas >= lo_acc);
      good_nxt = good_r;
      fail_nxt = fail_r;
      sts_nxt  = sts_r;
      if (judge) begin
         if (rej_hit) begin
            fail_nxt = (fail_r == '1) ? fail_r : fail_r + `RCM_LIM_W'(1);
            good_nxt = '0;
         end else if (acc_hit) begin
            fail_nxt = '0;
            good_nxt = (good_r == '1) ? good_r : good_r + `RCM_LIM_W'(1);
         end
         // between the thresholds both counters hold
         if (rej_hit && fail_nxt >= flim) begin
            sts_nxt = 1'b1;
         end else if (acc_hit && good_nxt >= glim) begin
            sts_nxt = 1'b0;
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         st_r   <= RCM_ST_ARM;
         cnt_r  <= '0;
         edg_r  <= '0;
         good_r <= '0;
         fail_r <= '0;
         sts_r  <= 1'b1;
      end else begin
         st_r   <= st_nxt;
         cnt_r  <= cnt_nxt;
         edg_r  <= edg_nxt;
         good_r <= good_nxt;
         fail_r <= fail_nxt;
         sts_r  <= sts_nxt;
      end
   end

   assign mon.sts = sts_r;
endmodule

// ### src/rcm_top.sv
// What this block does
// - Each reference gets a monitor core made of a loss-of-signal checker and an activity checker.
// - The loss-of-signal checker finds missing edges over a window timed by the system clock.
// - The activity checker counts the reference over a nominal 10 ms window for about 1 ppm.
// - Loss-of-signal checkers watch both references and the crystal, activity ones only the two.
// - Each count is compared with nominal plus and minus the accept and reject margins.
// - A count beyond the reject threshold bumps the failure counter and zeroes the good one.
// - A count inside the accept threshold zeroes the failure counter and bumps the good one.
// - Status clears when good count reaches its limit, or 1 for activity checking.
// - Status sets when failure count reaches its limit, or 1 for activity checking.
// - A reference is disqualified by the OR of its unmasked checker statuses.
// - Each valid-to-invalid status change sets a sticky event bit.
// - An event bit clears only by a write, and not while its failure persists.
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/10ps
`include "rcm_map.svh"

module rcm_top import rcm_pkg::*; (
   // clock and reset
   input  wire logic                   i_core_clk,
   input  wire logic                   i_nrst,
   // monitored references
   input  wire logic                   i_ref0,
   input  wire logic                   i_ref1,
   input  wire logic                   i_xtal,
   // register port
   input  wire logic [`RCM_ADDR_W-1:0] i_addr,
   input  wire logic [31:0]            i_wr_data,
   input  wire logic                   i_wr,
   input  wire logic                   i_rd,
   output logic      [31:0]            o_rd_data,
   // reference qualification: bit 0 ref0, bit 1 ref1, bit 2 crystal
   output logic      [2:0]             o_ref_disq
);
   rcm_cnt_t                nom_r [`RCM_NCHK];
   rcm_cnt_t                acc_r [`RCM_NCHK];
   rcm_cnt_t                rej_r [`RCM_NCHK];
   rcm_win_t                win_r [`RCM_NCHK];
   rcm_cnt_t                nom_nxt [`RCM_NCHK];
   rcm_cnt_t                acc_nxt [`RCM_NCHK];
   rcm_cnt_t                rej_nxt [`RCM_NCHK];
   rcm_win_t                win_nxt [`RCM_NCHK];
   rcm_lim_t                good_r, good_nxt;
   rcm_lim_t                fail_r, fail_nxt;
   logic [`RCM_NCHK-1:0]    mask_r, mask_nxt;
   logic [`RCM_NCHK-1:0]    evt_r, evt_nxt;
   logic [`RCM_NCHK-1:0]    prev_r, prev_nxt;
   logic [2:0]              disq_r, disq_nxt;
   logic [31:0]             rd_r, rd_nxt;
   logic [`RCM_NCHK-1:0]    sts;
   logic [`RCM_NCHK-1:0]    evt_clr;
   logic [2:0]              rise;
   logic [2:0]              ref_lvl;

   assign ref_lvl = {i_xtal, i_ref1, i_ref0};

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_edge
         rcm_edge_det u_edge (
            .i_core_clk (i_core_clk),
            .i_nrst     (i_nrst),
            .i_ref      (ref_lvl[g]),
            .o_rise     (rise[g])
         );
      end
   endgenerate

   rcm_chk_if chk [`RCM_NCHK] ();

   // checkers 0..2: short-term on ref0, ref1, crystal; 3..4: activity on ref0, ref1
   generate
      for (g = 0; g < `RCM_NCHK; g++) begin : g_chk
         assign chk[g].nom      = nom_r[g];
         assign chk[g].acc      = acc_r[g];
         assign chk[g].rej      = rej_r[g];
         assign chk[g].good_lim = good_r;
         assign chk[g].fail_lim = fail_r;
         assign sts[g]          = chk[g].sts;
         if (g < `RCM_NLOS) begin : g_los
            assign chk[g].win      = `RCM_WIN_W'(1);
            assign chk[g].ref_edge = rise[g];
            rcm_checker #(
               .INC       (`RCM_LOS_INC),
               .FIXED_LIM (1'b0)
            ) u_chk (
               .i_core_clk (i_core_clk),
               .i_nrst     (i_nrst),
               .mon        (chk[g])
            );
         end else begin : g_act
            assign chk[g].win      = win_r[g];
            assign chk[g].ref_edge = rise[g-`RCM_NLOS];
            rcm_checker #(
               .INC       (`RCM_ACT_INC),
               .FIXED_LIM (1'b1)
            ) u_chk (
               .i_core_clk (i_core_clk),
               .i_nrst     (i_nrst),
               .mon        (chk[g])
            );
         end
      end
   endgenerate

   // register writes
   always_comb begin
      good_nxt = good_r;
      fail_nxt = fail_r;
      mask_nxt = mask_r;
      evt_clr  = '0;
      for (int k = 0; k < `RCM_NCHK; k++) begin
         nom_nxt[k] = nom_r[k];
         acc_nxt[k] = acc_r[k];
         rej_nxt[k] = rej_r[k];
         win_nxt[k] = win_r[k];
         if (i_wr) begin
            if (i_addr == `RCM_ADDR_W'(`RCM_OFS_CHK_STRIDE * k + `RCM_OFS_NOM)) begin
               nom_nxt[k] = i_wr_data[`RCM_CNT_W-1:0];
            end else if (i_addr == `RCM_ADDR_W'(`RCM_OFS_CHK_STRIDE * k + `RCM_OFS_ACC)) begin
               acc_nxt[k] = i_wr_data[`RCM_CNT_W-1:0];
            end else if (i_addr == `RCM_ADDR_W'(`RCM_OFS_CHK_STRIDE * k + `RCM_OFS_REJ)) begin
               rej_nxt[k] = i_wr_data[`RCM_CNT_W-1:0];
            end else if (i_addr == `RCM_ADDR_W'(`RCM_OFS_CHK_STRIDE * k + `RCM_OFS_WIN)) begin
               win_nxt[k] = i_wr_data[`RCM_WIN_W-1:0];
            end
         end
      end
      if (i_wr) begin
         if (i_addr == `RCM_OFS_LIMITS) begin
            good_nxt = i_wr_data[`RCM_LIM_GOOD_LSB +: `RCM_LIM_W];
            fail_nxt = i_wr_data[`RCM_LIM_FAIL_LSB +: `RCM_LIM_W];
         end else if (i_addr == `RCM_OFS_MASK) begin
            mask_nxt = i_wr_data[`RCM_NCHK-1:0];
         end else if (i_addr == `RCM_OFS_EVENT) begin
            evt_clr = i_wr_data[`RCM_NCHK-1:0];
         end
      end
   end

   // events, qualification and read data
   always_comb begin
      prev_nxt = sts;
      // a new failure wins over a clear in the same cycle
      evt_nxt  = (evt_r & ~(evt_clr & ~sts)) | (sts & ~prev_r);
      disq_nxt[0] = (sts[0] & ~mask_r[0]) | (sts[3] & ~mask_r[3]);
      disq_nxt[1] = (sts[1] & ~mask_r[1]) | (sts[4] & ~mask_r[4]);
      disq_nxt[2] = sts[2] & ~mask_r[2];
      rd_nxt = '0;
      if (i_rd) begin
         for (int k = 0; k < `RCM_NCHK; k++) begin
            if (i_addr == `RCM_ADDR_W'(`RCM_OFS_CHK_STRIDE * k + `RCM_OFS_NOM)) begin
               rd_nxt = 32'(nom_r[k]);
            end else if (i_addr == `RCM_ADDR_W'(`RCM_OFS_CHK_STRIDE * k + `RCM_OFS_ACC)) begin
               rd_nxt = 32'(acc_r[k]);
            end else if (i_addr == `RCM_ADDR_W'(`RCM_OFS_CHK_STRIDE * k + `RCM_OFS_REJ)) begin
               rd_nxt = 32'(rej_r[k]);
            end else if (i_addr == `RCM_ADDR_W'(`RCM_OFS_CHK_STRIDE * k + `RCM_OFS_WIN)) begin
               rd_nxt = 32'(win_r[k]);
            end
         end
         if (i_addr == `RCM_OFS_LIMITS) begin
            rd_nxt = {16'h0000, fail_r, good_r};
         end else if (i_addr == `RCM_OFS_MASK) begin
            rd_nxt = 32'(mask_r);
         end else if (i_addr == `RCM_OFS_STATUS) begin
            rd_nxt = 32'(sts) | (32'(disq_r) << `RCM_STS_DISQ_LSB);
         end else if (i_addr == `RCM_OFS_EVENT) begin
            rd_nxt = 32'(evt_r);
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         for (int k = 0; k < `RCM_NCHK; k++) begin
            nom_r[k] <= `RCM_RST_NOM;
            acc_r[k] <= `RCM_RST_ACC;
            rej_r[k] <= `RCM_RST_REJ;
            win_r[k] <= `RCM_RST_WIN;
         end
         good_r <= `RCM_RST_GOOD;
         fail_r <= `RCM_RST_FAIL;
         mask_r <= `RCM_RST_MASK;
         evt_r  <= '0;
         prev_r <= '1;
         disq_r <= '1;
         rd_r   <= '0;
      end else begin
         for (int k = 0; k < `RCM_NCHK; k++) begin
            nom_r[k] <= nom_nxt[k];
            acc_r[k] <= acc_nxt[k];
            rej_r[k] <= rej_nxt[k];
            win_r[k] <= win_nxt[k];
         end
         good_r <= good_nxt;
         fail_r <= fail_nxt;
         mask_r <= mask_nxt;
         evt_r  <= evt_nxt;
         prev_r <= prev_nxt;
         disq_r <= disq_nxt;
         rd_r   <= rd_nxt;
      end
   end

   assign o_rd_data  = rd_r;
   assign o_ref_disq = disq_r;
endmodule

// ### tb/rcm_ref_src.sv
`timescale 1ns/10ps

module rcm_ref_src (
   // clock
   input  wire logic       i_core_clk,
   // period of each source in clock cycles, 0 stops it low
   input  wire logic [7:0] i_per0,
   input  wire logic [7:0] i_per1,
   input  wire logic [7:0] i_per2,
   // reference levels
   output logic            o_ref0,
   output logic            o_ref1,
   output logic            o_xtal
);
   wire logic [7:0] per [3];
   logic      [7:0] cnt [3];
   logic      [2:0] lvl;

   assign per[0] = i_per0;
   assign per[1] = i_per1;
   assign per[2] = i_per2;
   assign o_ref0 = lvl[0];
   assign o_ref1 = lvl[1];
   assign o_xtal = lvl[2];

   // periods of 4 cycles or more keep the source 8x under the doubled clock
   // periods of 8 cycles or more span at least 8 measuring-clock periods per window
   always @(posedge i_core_clk) begin
      for (int k = 0; k < 3; k++) begin
         if (per[k] == 8'h00 || cnt[k] + 8'h01 >= per[k]) begin
            cnt[k] <= 8'h00;
         end else begin
            cnt[k] <= cnt[k] + 8'h01;
         end
         lvl[k] <= (per[k] != 8'h00) && (cnt[k] < (per[k] >> 1));
      end
   end
endmodule

// ### tb/rcm_top_properties.sv
`timescale 1ns/10ps
`include "rcm_map.svh"

module rcm_top_properties (
   // clock and reset
   input  wire logic        i_core_clk,
   input  wire logic        i_nrst,
   // register port and qualification
   input  wire logic [7:0]  i_addr,
   input  wire logic [31:0] i_wr_data,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   input  wire logic [31:0] o_rd_data,
   input  wire logic [2:0]  o_ref_disq
);
   logic        wr_seen_r;
   logic [7:0]  wr_addr_r;
   logic [31:0] wr_data_r;

   // remembers the last write so a following read can be compared
   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         wr_seen_r <= 1'b0;
      end else if (i_wr) begin
         wr_seen_r <= 1'b1;
      end
      if (i_wr) begin
         wr_addr_r <= i_addr;
         wr_data_r <= i_wr_data;
      end
   end

   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);

   sequence rd_at(logic [7:0] a);
      i_rd && i_addr == a;
   endsequence
   sequence mask_all_wr;
      i_wr && i_addr == `RCM_OFS_MASK && i_wr_data[4:0] == 5'h1F;
   endsequence
   sequence rd_last_wr;
      wr_seen_r && i_rd && i_addr == wr_addr_r;
   endsequence

   rd_idle_zero_a: assert property (!i_rd |=> o_rd_data == 32'h0)
      else $error("read data not zero outside a read");
   unmapped_rd_a: assert property ((i_rd && (i_addr >= 8'h70 || i_addr[7:4] == 4'h5))
      |=> o_rd_data == 32'h0) else $error("unmapped read not zero");
   status_copy_a: assert property (rd_at(`RCM_OFS_STATUS) |=> o_rd_data[10:8] ==
      $past(o_ref_disq) && o_rd_data[31:11] == 21'h0 && o_rd_data[7:5] == 3'h0)
      else $error("status read disagrees with qualification");
   event_rsvd_a: assert property (rd_at(`RCM_OFS_EVENT) |=> o_rd_data[31:5] == 27'h0)
      else $error("event read has extra bits");
   reset_disq_a: assert property ($rose(i_nrst) |-> o_ref_disq == 3'h7)
      else $error("references not disqualified after reset");
   mask_hide_a: assert property (mask_all_wr |-> ##2 o_ref_disq == 3'h0)
      else $error("masked statuses still disqualify");
   nom_readback_a: assert property ((rd_last_wr ##0 (i_addr[3:0] == 4'h0 &&
      i_addr < 8'h50)) |=> o_rd_data == {8'h00, wr_data_r[23:0]})
      else $error("nominal readback wrong");
   limits_readback_a: assert property ((rd_last_wr ##0 i_addr == `RCM_OFS_LIMITS)
      |=> o_rd_data == {16'h0000, wr_data_r[15:0]}) else $error("limits readback wrong");
endmodule

bind rcm_top rcm_top_properties i_rcm_top_properties (
   .i_core_clk (i_core_clk),
   .i_nrst     (i_nrst),
   .i_addr     (i_addr),
   .i_wr_data  (i_wr_data),
   .i_wr       (i_wr),
   .i_rd       (i_rd),
   .o_rd_data  (o_rd_data),
   .o_ref_disq (o_ref_disq)
);

// ### tb/testbench.sv
`timescale 1ns/10ps
`include "rcm_map.svh"

module testbench;
   logic        i_core_clk;
   logic        i_nrst;
   logic [7:0]  i_addr;
   logic [31:0] i_wr_data;
   logic        i_wr;
   logic        i_rd;
   logic [31:0] o_rd_data;
   logic [2:0]  o_ref_disq;
   logic [2:0]  refs;
   logic [7:0]  per0;
   logic [7:0]  per1;
   logic [7:0]  per2;
   int          error_cnt;
   int          total_checks;
   int          cyc;

   always #12.5 i_core_clk = ~i_core_clk;

   rcm_top i_rcm_top (
      .i_core_clk (i_core_clk),
      .i_nrst     (i_nrst),
      .i_ref0     (refs[0]),
      .i_ref1     (refs[1]),
      .i_xtal     (refs[2]),
      .i_addr     (i_addr),
      .i_wr_data  (i_wr_data),
      .i_wr       (i_wr),
      .i_rd       (i_rd),
      .o_rd_data  (o_rd_data),
      .o_ref_disq (o_ref_disq)
   );

   rcm_ref_src i_rcm_ref_src (
      .i_core_clk (i_core_clk),
      .i_per0     (per0),
      .i_per1     (per1),
      .i_per2     (per2),
      .o_ref0     (refs[0]),
      .o_ref1     (refs[1]),
      .o_xtal     (refs[2])
   );

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_core_clk);
      i_wr      <= 1'b1;
      i_addr    <= a;
      i_wr_data <= d;
      @(posedge i_core_clk);
      i_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
      @(posedge i_core_clk);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_core_clk);
      i_rd <= 1'b0;
      #1 chk(name, o_rd_data, exp);
   endtask

   task automatic wait_disq(input logic [2:0] exp, input int lim);
      int n;
      n = 0;
      while (o_ref_disq !== exp && n < lim) begin
         @(posedge i_core_clk);
         #1 n++;
      end
      chk("disq", {29'h0, o_ref_disq}, {29'h0, exp});
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   always @(posedge i_core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         $display("[FAIL] run time expected under 20000 seen 20000");
         end_sim();
      end
   end

   initial begin
      i_core_clk   = 1'b0;
      i_nrst       = 1'b0;
      i_addr       = 8'h00;
      i_wr_data    = 32'h0;
      i_wr         = 1'b0;
      i_rd         = 1'b0;
      per0         = 8'h00;
      per1         = 8'h00;
      per2         = 8'h00;
      error_cnt    = 0;
      total_checks = 0;
      cyc          = 0;
      repeat (3) @(posedge i_core_clk);
      i_nrst <= 1'b1;
      for (int k = 0; k < 5; k++) begin
         rd(8'(k * 16), 32'h10, "nom");
         rd(8'(k * 16 + 4), 32'h1, "acc");
         rd(8'(k * 16 + 8), 32'h2, "rej");
         rd(8'(k * 16 + 12), 32'h1, "win");
      end
      rd(`RCM_OFS_LIMITS, 32'h0202, "limits");
      rd(`RCM_OFS_STATUS, 32'h71F, "status");
      rd(`RCM_OFS_EVENT, 32'h0, "event");
      wr(8'h70, 32'hFFFF_FFFF);
      rd(8'h70, 32'h0, "unmapped");
      wr(`RCM_OFS_LIMITS, 32'h0305);
      rd(`RCM_OFS_LIMITS, 32'h0305, "limits wr");
      wr(`RCM_OFS_LIMITS, 32'h0202);
      $display("test reset_regs done");
      // activity nominal: one edge of an 8-cycle reference
      wr(8'h30, 32'h8);
      wr(8'h40, 32'h8);
      rd(8'h40, 32'h8, "act nom");
      per0 <= 8'h08;
      per1 <= 8'h08;
      per2 <= 8'h08;
      wait_disq(3'h0, 300);
      rd(`RCM_OFS_STATUS, 32'h0, "status good");
      rd(`RCM_OFS_EVENT, 32'h0, "no event");
      $display("test qualify done");
      per2 <= 8'h00;
      wait_disq(3'h4, 300);
      rd(`RCM_OFS_STATUS, 32'h404, "status loss");
      rd(`RCM_OFS_EVENT, 32'h4, "event set");
      wr(`RCM_OFS_EVENT, 32'h1F);
      rd(`RCM_OFS_EVENT, 32'h4, "event held");
      per2 <= 8'h08;
      wait_disq(3'h0, 300);
      rd(`RCM_OFS_EVENT, 32'h4, "event sticky");
      wr(`RCM_OFS_EVENT, 32'h4);
      rd(`RCM_OFS_EVENT, 32'h0, "event clr");
      $display("test loss_event done");
      // 9-cycle period lands between accept and reject for the short-term check
      per0 <= 8'h09;
      repeat (200) @(posedge i_core_clk);
      rd(`RCM_OFS_STATUS, 32'h0, "between");
      per0 <= 8'h08;
      $display("test between done");
      wr(`RCM_OFS_MASK, 32'h02);
      per1 <= 8'h0C;
      wait_disq(3'h2, 300);
      repeat (100) @(posedge i_core_clk);
      rd(`RCM_OFS_STATUS, 32'h212, "act fail");
      rd(`RCM_OFS_EVENT, 32'h12, "act event");
      wr(`RCM_OFS_MASK, 32'h12);
      wait_disq(3'h0, 10);
      wr(`RCM_OFS_MASK, 32'h1F);
      per2 <= 8'h00;
      repeat (100) @(posedge i_core_clk);
      chk("disq masked", {29'h0, o_ref_disq}, 32'h0);
      wr(`RCM_OFS_MASK, 32'h00);
      wait_disq(3'h6, 10);
      per1 <= 8'h08;
      per2 <= 8'h08;
      wait_disq(3'h0, 300);
      wr(`RCM_OFS_EVENT, 32'h1F);
      rd(`RCM_OFS_EVENT, 32'h0, "events clr");
      wr(`RCM_OFS_STATUS, 32'h1F);
      rd(`RCM_OFS_STATUS, 32'h0, "status ro");
      $display("test mask done");
      end_sim();
   end
endmodule
